// ===== hw/cpwm_unit.sv
`timescale 1ns/1ps
module cpwm_unit (
   input  wire logic                            i_clk_sys,
   input  wire logic                            i_rst,
   input  wire logic                            i_sleep,
   input  wire logic                            i_unit_enable,
   input  wire logic [cpwm_pkg::MODE_W-1:0]     i_unit_mode_select,
   input  wire logic                            i_duty_align_select,
   input  wire logic [7:0]                      i_duty_value_high,
   input  wire logic [7:0]                      i_duty_value_low,
   input  wire logic [cpwm_pkg::TMR_W-1:0]      i_period_limit,
   input  wire logic [1:0]                      i_period_timer_prescale,
   input  wire logic                            i_period_timer_run,
   input  wire logic                            i_period_timer_flag_clear,
   input  wire logic [7:0]                      i_timer_one_count_high,
   input  wire logic [7:0]                      i_timer_one_count_low,
   input  wire logic                            i_unit_event_irq_enable,
   input  wire logic                            i_unit_event_flag_clear,
   input  wire logic                            i_pin_direction,
   output wire logic                            o_unit_output_pin,
   output wire logic                            o_unit_output_pin_oe,
   output wire logic [cpwm_pkg::TMR_W-1:0]      o_period_timer_count,
   output wire logic                            o_period_timer_flag,
   output wire logic                            o_unit_event_flag,
   output wire logic                            o_wake_request,
   output wire logic [cpwm_pkg::STEPS_W-1:0]    o_pwm_period_steps,
   output wire logic                            o_pwm_full_resolution
);

   cpwm_tmr_if tif ();

   logic                          out_reg;
   logic                          out_next;
   logic [cpwm_pkg::DUTY_W-1:0]   duty_buf_reg;
   logic [cpwm_pkg::DUTY_W-1:0]   duty_buf_next;
   logic                          tmr_flag_reg;
   logic                          tmr_flag_next;
   logic                          evt_flag_reg;
   logic                          evt_flag_next;
   logic [cpwm_pkg::STEPS_W-1:0]  steps_reg;
   logic [cpwm_pkg::STEPS_W-1:0]  steps_next;
   logic                          full_res_reg;
   logic                          full_res_next;

   wire                           pwm_on;
   wire                           cmp_on;
   wire                           cmp_match;
   wire  [cpwm_pkg::DUTY_W-1:0]   duty_left;
   wire  [cpwm_pkg::DUTY_W-1:0]   duty_right;
   wire  [cpwm_pkg::DUTY_W-1:0]   duty_regs;
   wire  [cpwm_pkg::DUTY_W-1:0]   time_base;
   wire  [cpwm_pkg::DUTY_W-1:0]   duty_minus_one;
   wire                           duty_reached;
   wire                           period_end;

   cpwm_period_timer u_timer (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .tif       (tif.timer)
   );

   // Sleep stops the system clock in the real part; here it gates state.
   assign tif.hold     = i_sleep; // R16
   assign tif.run      = i_period_timer_run;
   assign tif.prescale = i_period_timer_prescale;
   assign tif.limit    = i_period_limit;
   assign period_end   = tif.period_end;

   assign pwm_on = i_unit_enable &&
                   (i_unit_mode_select == cpwm_pkg::MODE_PWM); // R20
   assign cmp_on = i_unit_enable &&
                   cpwm_pkg::is_compare(i_unit_mode_select);

   assign cmp_match = cmp_on &&
      ({i_duty_value_high, i_duty_value_low} ==
       {i_timer_one_count_high, i_timer_one_count_low}); // R01

   assign duty_left  = {i_duty_value_high,
                        i_duty_value_low[7:8-cpwm_pkg::PHASE_W]}; // R22
   assign duty_right = {i_duty_value_high[cpwm_pkg::PHASE_W-1:0],
                        i_duty_value_low}; // R23
   assign duty_regs  = (i_duty_align_select == cpwm_pkg::ALIGN_LEFT) ?
                       duty_left : duty_right; // R10 R21

   assign time_base = {tif.count, tif.phase}; // R03 R12
   assign duty_minus_one = duty_buf_reg - 1'b1;
   // Clearing on the last cycle of step duty-1 makes the pin fall exactly
   // as the time base reaches the duty value, so the high time is
   // duty times prescale system clocks with a registered output.
   assign duty_reached = tif.step_end && (time_base == duty_minus_one);

   always_comb begin
      out_next      = out_reg;
      duty_buf_next = duty_buf_reg;
      if (!pwm_on) begin
         out_next = 1'b0;
      end else if (i_sleep) begin
         out_next = out_reg; // R16
      end else if (period_end) begin
         duty_buf_next = duty_regs; // R07 R09 R11
         out_next      = (duty_regs != '0); // R06
      end else if (duty_reached && duty_buf_reg != '0) begin
         // A duty beyond the period is never reached, so the pin stays.
         out_next = 1'b0; // R13 R15
      end
   end

   // Hardware set wins over a software clear in the same cycle.
   assign tmr_flag_next = period_end ||
                          (tmr_flag_reg && !i_period_timer_flag_clear);
   assign evt_flag_next = cmp_match ||
                          (evt_flag_reg && !i_unit_event_flag_clear); // R01

   assign steps_next = STEPS_W_CAST(({3'h0, i_period_limit} + 11'h001)
                                    << cpwm_pkg::PHASE_W); // R14
   assign full_res_next = (i_period_limit == '1); // R14

   function automatic logic [cpwm_pkg::STEPS_W-1:0] STEPS_W_CAST(
      input logic [cpwm_pkg::STEPS_W-1:0] v);
      STEPS_W_CAST = v;
   endfunction

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         out_reg      <= 1'b0;
         duty_buf_reg <= '0;
         tmr_flag_reg <= 1'b0;
         evt_flag_reg <= 1'b0;
         steps_reg    <= '0;
         full_res_reg <= 1'b0;
      end else begin
         out_reg      <= out_next;
         duty_buf_reg <= duty_buf_next;
         tmr_flag_reg <= tmr_flag_next;
         evt_flag_reg <= evt_flag_next;
         steps_reg    <= steps_next;
         full_res_reg <= full_res_next;
      end
   end

   assign o_unit_output_pin     = out_reg; // R03
   // The driver is enabled only while the direction bit selects output.
   assign o_unit_output_pin_oe  = !i_pin_direction; // R19
   assign o_period_timer_count  = tif.count;
   assign o_period_timer_flag   = tmr_flag_reg; // R18
   assign o_unit_event_flag     = evt_flag_reg;
   assign o_wake_request        = i_sleep && i_unit_event_irq_enable &&
                                  evt_flag_reg; // R02
   assign o_pwm_period_steps    = steps_reg;
   assign o_pwm_full_resolution = full_res_reg;

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   evt_flag_set_a: assert property (cmp_match |=> o_unit_event_flag) // R01
      else $error("compare match did not set the event flag");

   wake_req_a: assert property (
      i_sleep && i_unit_event_irq_enable && cmp_match
      |=> o_wake_request || !i_sleep || !i_unit_event_irq_enable) // R02
      else $error("enabled compare match did not wake the device");

   pin_set_a: assert property (
      pwm_on && !i_sleep && period_end && duty_regs != '0
      |=> o_unit_output_pin) // R06
      else $error("pin not set at period end");

   zero_duty_a: assert property (
      pwm_on && !i_sleep && period_end && duty_regs == '0
      |=> !o_unit_output_pin) // R06
      else $error("pin set although duty is zero");

   buf_load_a: assert property (
      pwm_on && !i_sleep && period_end
      |=> duty_buf_reg == $past(duty_regs)) // R07
      else $error("duty buffer not loaded at period end");

   buf_hold_a: assert property (
      !(pwm_on && !i_sleep && period_end) |=> $stable(duty_buf_reg)) // R09
      else $error("duty buffer changed mid-period");

   pin_clear_a: assert property (
      pwm_on && !i_sleep && !period_end && duty_reached &&
      duty_buf_reg != '0 |=> !o_unit_output_pin) // R13
      else $error("pin not cleared when time base met duty");

   over_period_a: assert property (
      pwm_on && !i_sleep && !period_end && o_unit_output_pin &&
      duty_buf_reg > {i_period_limit, 2'h3}
      |=> o_unit_output_pin) // R15
      else $error("pin cleared by a duty beyond the period");

   sleep_hold_a: assert property (
      pwm_on && i_sleep ##1 pwm_on && i_sleep
      |-> $stable(o_unit_output_pin) && $stable(o_period_timer_count)) // R16
      else $error("state changed during sleep");

   pwm_off_a: assert property (!pwm_on |=> !o_unit_output_pin) // R20
      else $error("pin high outside PWM mode");

   align_left_a: assert property (
      i_duty_align_select |-> duty_regs[1:0] == i_duty_value_low[7:6]) // R22
      else $error("left-aligned duty bits misplaced");

   steps_a: assert property (
      ##1 $stable(i_period_limit)
      |=> o_pwm_period_steps == 11'(({3'h0, i_period_limit} + 11'h001) * 4))
      // R14
      else $error("period step count wrong");

   period_cov: cover property (pwm_on && period_end && duty_regs != '0
                               ##[1:600] !o_unit_output_pin);
   cmp_cov: cover property (cmp_match ##1 o_unit_event_flag);
   wake_cov: cover property (o_wake_request);
   sleep_cov: cover property (pwm_on && o_unit_output_pin && i_sleep [*4]);

endmodule

// ===== hw/cpwm_pkg.sv
// Notes on behaviour
// R01: Compare match of timer one sets event flag.
// R02: Enabled compare event wakes sleeping device.
// R03: PWM waveform on pin, ten-bit resolution.
// R04: Period equals (limit+1) times four times prescale.
// R05: Period end clears period timer count.
// R06: Period end sets pin unless duty zero.
// R07: Period end loads duty into buffer.
// R08: Postscaler never affects PWM period.
// R09: New duty applies only after period end.
// R10: Alignment bit chooses duty bit placement.
// R11: Duty double-buffered so output never glitches.
// R12: Time base is count plus two phase bits.
// R13: Time base reaching duty clears the pin.
// R14: Resolution is log2 of four times (limit+1).
// R15: Duty beyond period leaves pin unchanged.
// R16: Sleep freezes timer, state and pin level.
// R17: Software follows the documented setup order.
// R18: Software waits for timer flag before driving.
// R19: Pin direction must be output for waveform.
// R20: Mode field 1111 selects PWM operation.
// R21: Alignment 0 is right, 1 is left.
// R22: Left: duty high byte, low bits 7:6.
// R23: Right: duty low byte, high bits 1:0.
package cpwm_pkg;

   localparam int TMR_W   = 8;
   localparam int PHASE_W = 2;
   localparam int DUTY_W  = TMR_W + PHASE_W;
   localparam int PRE_W   = 8;
   localparam int STEPS_W = DUTY_W + 1;
   localparam int MODE_W  = 4;

   localparam logic [MODE_W-1:0] MODE_OFF      = 4'h0;
   localparam logic [MODE_W-1:0] MODE_TOG_CLR  = 4'h1;
   localparam logic [MODE_W-1:0] MODE_TOG      = 4'h2;
   localparam logic [MODE_W-1:0] MODE_CMP_LO   = 4'h8;
   localparam logic [MODE_W-1:0] MODE_CMP_HI   = 4'hb;
   localparam logic [MODE_W-1:0] MODE_PWM      = 4'hf;

   localparam logic ALIGN_RIGHT = 1'b0;
   localparam logic ALIGN_LEFT  = 1'b1;

   // Prescale codes: 1:1, 1:4, 1:16, 1:64.
   typedef enum logic [1:0] {
      CPWM_PS_1,
      CPWM_PS_4,
      CPWM_PS_16,
      CPWM_PS_64
   } cpwm_ps_t;

   localparam logic [2:0] PS_SHIFT_STEP = 3'h2;

   // Log2 of the prescale ratio.
   function automatic logic [2:0] ps_shift(input logic [1:0] ps);
      ps_shift = 3'(ps) * PS_SHIFT_STEP;
   endfunction

   // Mask of ones, prescale cycles per time-base step minus one.
   function automatic logic [PRE_W-1:0] step_mask(input logic [1:0] ps);
      step_mask = PRE_W'((9'h001 << ps_shift(ps)) - 9'h001);
   endfunction

   // Last prescaler value before the period timer advances.
   function automatic logic [PRE_W-1:0] pre_last(input logic [1:0] ps);
      pre_last = PRE_W'((9'h004 << ps_shift(ps)) - 9'h001);
   endfunction

   function automatic logic is_compare(input logic [MODE_W-1:0] m);
      is_compare = (m == MODE_TOG_CLR) || (m == MODE_TOG) ||
                   ((m >= MODE_CMP_LO) && (m <= MODE_CMP_HI));
   endfunction

endpackage

// ===== hw/cpwm_tmr_if.sv
`timescale 1ns/1ps
interface cpwm_tmr_if;
   logic                         hold;
   logic                         run;
   logic [1:0]                   prescale;
   logic [cpwm_pkg::TMR_W-1:0]   limit;
   logic [cpwm_pkg::TMR_W-1:0]   count;
   logic [cpwm_pkg::PHASE_W-1:0] phase;
   logic                         step_end;
   logic                         period_end;

   modport timer (
      input  hold,
      input  run,
      input  prescale,
      input  limit,
      output count,
      output phase,
      output step_end,
      output period_end
   );

   modport user (
      output hold,
      output run,
      output prescale,
      output limit,
      input  count,
      input  phase,
      input  step_end,
      input  period_end
   );
endinterface

// ===== hw/cpwm_period_timer.sv
`timescale 1ns/1ps
module cpwm_period_timer (
   input wire logic       i_clk_sys,
   input wire logic       i_rst,
   cpwm_tmr_if.timer      tif
);

   logic [cpwm_pkg::PRE_W-1:0] pre_reg;
   logic [cpwm_pkg::PRE_W-1:0] pre_next;
   logic [cpwm_pkg::TMR_W-1:0] cnt_reg;
   logic [cpwm_pkg::TMR_W-1:0] cnt_next;
   wire                        active;
   wire                        tick;
   wire                        at_limit;
   wire  [cpwm_pkg::PRE_W-1:0] pre_shr;

   // The prescaler counts system clocks, four per instruction clock.
   assign active   = tif.run && !tif.hold; // R16
   assign tick     = active && (pre_reg == cpwm_pkg::pre_last(tif.prescale));
   assign at_limit = (cnt_reg == tif.limit);
   // No postscaler exists here, so the period depends on limit and prescale only.
   assign tif.period_end = tick && at_limit; // R04 R08
   assign pre_next = tick ? '0 : pre_reg + 1'b1;
   assign cnt_next = at_limit ? '0 : cnt_reg + 1'b1; // R05

   // At 1:1 these are the clock phase, else the prescaler's step bits.
   assign pre_shr  = pre_reg >> cpwm_pkg::ps_shift(tif.prescale);
   assign tif.phase = pre_shr[cpwm_pkg::PHASE_W-1:0]; // R12
   assign tif.step_end = (pre_reg & cpwm_pkg::step_mask(tif.prescale)) ==
                         cpwm_pkg::step_mask(tif.prescale);
   assign tif.count = cnt_reg;

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         pre_reg <= '0;
         cnt_reg <= '0;
      end else if (active) begin
         pre_reg <= pre_next;
         if (tick) begin
            cnt_reg <= cnt_next;
         end
      end
   end

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   period_wrap_a: assert property (tif.period_end |=> cnt_reg == '0) // R05
      else $error("period timer did not wrap at the limit");
   count_step_a: assert property (tick && !at_limit
                                  |=> cnt_reg == $past(cnt_reg) + 1'b1) // R04
      else $error("period timer failed to advance");
   phase_1to1_a: assert property (tif.prescale == 2'h0 && active
      |-> tif.phase == pre_reg[cpwm_pkg::PHASE_W-1:0] && tif.step_end) // R12
      else $error("time base low bits not the clock phase at 1:1");

endmodule

// ===== tb/cpwm_load_model.sv
`timescale 1ns/1ps
module cpwm_load_model (
   input  wire logic i_clk_sys,
   input  wire logic i_pin,
   input  wire logic i_oe,
   output wire logic o_level,
   output int        o_high_len
);
   int run_len = 0;

   // The load line has a pull-down, so a released pin reads low.
   assign o_level = i_oe ? i_pin : 1'b0;

   // Length of the last complete high pulse, in system clocks.
   always @(posedge i_clk_sys) begin
      if (o_level === 1'b1) begin
         run_len <= run_len + 1;
      end else begin
         if (run_len != 0) begin
            o_high_len <= run_len;
         end
         run_len <= 0;
      end
   end
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
   $display("BAD %s exp %0h got %0h", nm, e, g); end end

module testbench;
   logic        i_clk_sys = 1'b0, i_rst = 1'b1, i_sleep = 1'b0;
   logic        i_unit_enable = 1'b1, i_duty_align_select = 1'b0;
   logic        i_period_timer_run = 1'b1, i_period_timer_flag_clear = 1'b1;
   logic        i_unit_event_irq_enable = 1'b0, i_pin_direction = 1'b0;
   logic        i_unit_event_flag_clear = 1'b0;
   logic [3:0]  i_unit_mode_select = 4'hf;
   logic [1:0]  i_period_timer_prescale = 2'h0;
   logic [7:0]  i_duty_value_high = 8'h00, i_duty_value_low = 8'h00;
   logic [7:0]  i_period_limit = 8'h00, i_timer_one_count_high = 8'h00;
   logic [7:0]  i_timer_one_count_low = 8'h00, o_period_timer_count;
   logic        o_unit_output_pin, o_unit_output_pin_oe, o_period_timer_flag;
   logic        o_unit_event_flag, o_wake_request, o_pwm_full_resolution;
   logic [10:0] o_pwm_period_steps;
   logic        lvl;
   logic [31:0] seed = 32'he69aa0eb;
   int          m_pre, m_cnt, m_buf, m_pin, m_pf, m_ef, m_st, m_fr, tb, pe;
   int          errors, n_checks, ncyc, hi_len, last_pe = -1;
   // Period lengths are only measured while the flag clear is held high.
   int          chk_per = 1;
   int          tbl[5] = '{20, 0, 40, 32, 5};

   cpwm_unit dut_u (.*);
   cpwm_load_model load_u (.i_clk_sys(i_clk_sys), .i_pin(o_unit_output_pin),
      .i_oe(o_unit_output_pin_oe), .o_level(lvl), .o_high_len(hi_len));

   initial forever #25 i_clk_sys = ~i_clk_sys;

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Reference model, advanced on the same edge as the design.
   always @(posedge i_clk_sys) begin
      if (i_rst) begin
         {m_pre, m_cnt, m_buf, m_pin, m_pf, m_ef, m_st, m_fr} = '0;
         last_pe = -1;
      end else begin
         m_st = 4 * (i_period_limit + 1);
         m_fr = (i_period_limit == 255);
         if (!i_sleep) begin
            pe = 0;
            if (i_period_timer_run) begin
               if (m_pre == 4 * (1 << 2 * i_period_timer_prescale) - 1) begin
                  m_pre = 0;
                  pe = (m_cnt == i_period_limit);
                  m_cnt = pe ? 0 : m_cnt + 1;
               end else begin
                  m_pre++;
               end
            end
            tb = m_cnt * 4 + (m_pre >> 2 * i_period_timer_prescale) % 4;
            if (pe && i_unit_enable && i_unit_mode_select == 4'hf) begin
               m_buf = i_duty_align_select ?
                  i_duty_value_high * 4 + i_duty_value_low / 64 :
                  (i_duty_value_high % 4) * 256 + i_duty_value_low;
               m_pin = (m_buf != 0);
            end else if (tb == m_buf) begin
               m_pin = 0;
            end
            m_pf = pe | (m_pf & !i_period_timer_flag_clear);
         end
         if (!(i_unit_enable && i_unit_mode_select == 4'hf)) m_pin = 0;
         m_ef = (i_unit_enable && (i_unit_mode_select inside {1, 2, [8:11]})
            && {i_duty_value_high, i_duty_value_low} ==
            {i_timer_one_count_high, i_timer_one_count_low})
            | (m_ef & !i_unit_event_flag_clear);
      end
   end

   // Inputs change by non-blocking assignment, so this sees settled values.
   always @(negedge i_clk_sys) begin
      ncyc++;
      `CHK("pin", m_pin, o_unit_output_pin)
      `CHK("count", m_cnt, o_period_timer_count)
      `CHK("pflag", m_pf, o_period_timer_flag)
      `CHK("eflag", m_ef, o_unit_event_flag)
      `CHK("wake", i_sleep & i_unit_event_irq_enable & m_ef,
           o_wake_request)
      `CHK("oe", !i_pin_direction, o_unit_output_pin_oe)
      `CHK("load", i_pin_direction ? 0 : m_pin, lvl)
      `CHK("steps", m_st, o_pwm_period_steps)
      `CHK("fullres", m_fr, o_pwm_full_resolution)
      if (o_period_timer_flag === 1'b1 && i_period_timer_flag_clear &&
          chk_per) begin
         if (last_pe >= 0) `CHK("period", (i_period_limit + 1) * 4 *
            (1 << 2 * i_period_timer_prescale), ncyc - last_pe)
         last_pe = ncyc;
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(negedge i_clk_sys);
   endtask

   task automatic restart(input int lim, input int ps);
      @(negedge i_clk_sys);
      i_rst <= 1'b1;
      i_period_limit <= 8'(lim);
      i_period_timer_prescale <= 2'(ps);
      i_period_timer_flag_clear <= 1'b1;
      i_unit_mode_select <= 4'hf;
      i_unit_enable <= 1'b1;
      cyc(2);
      i_rst <= 1'b0;
   endtask

   // Unused duty bits carry noise so a wrong field placement shows up.
   task automatic put_duty(input int d, input logic a);
      logic [9:0]  v;
      logic [31:0] r;
      v = 10'(d);
      r = rnd();
      i_duty_align_select <= a;
      i_duty_value_high <= a ? v[9:2] : {r[7:2], v[9:8]};
      i_duty_value_low <= a ? {v[1:0], r[13:8]} : v[7:0];
   endtask

   task automatic endt(input string s);
      $display("test %s finished", s);
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      logic [31:0] r;
      int          d;
      for (int p = 0; p < 4; p++) begin
         restart(3, p);
         d = int'(rnd() % 15) + 1;
         put_duty(d, 1'(p));
         cyc(64 * (1 << 2 * p) + 20);
         `CHK("high", d * (1 << 2 * p), hi_len)
      end
      endt("prescale");
      restart(7, 0);
      put_duty(10, 1'b0);
      foreach (tbl[k]) begin
         cyc(45);
         put_duty(tbl[k], 1'(k));
      end
      cyc(70);
      endt("duty update");
      restart(15, 1);
      put_duty(40, 1'b1);
      i_period_timer_flag_clear <= 1'b0;
      cyc(300);
      i_sleep <= 1'b1;
      cyc(50);
      i_sleep <= 1'b0;
      cyc(300);
      endt("sleep");
      chk_per = 0;
      restart(3, 0);
      for (int i = 0; i < 32; i++) begin
         r = rnd();
         i_unit_mode_select <= 4'(i);
         i_unit_enable <= (i < 16);
         i_sleep <= i[1];
         i_unit_event_irq_enable <= i[2];
         i_period_timer_flag_clear <= 1'b0;
         {i_duty_value_high, i_duty_value_low} <= r[15:0];
         {i_timer_one_count_high, i_timer_one_count_low} <= r[15:0];
         cyc(2);
         i_timer_one_count_low <= r[7:0] + 8'h01;
         cyc(2);
         // Flags are only cleared while awake to keep clear and freeze apart.
         i_sleep <= 1'b0;
         i_unit_event_flag_clear <= 1'b1;
         i_period_timer_flag_clear <= 1'b1;
         cyc(1);
         i_unit_event_flag_clear <= 1'b0;
         cyc(1);
      end
      endt("compare");
      restart(255, 0);
      chk_per = 1;
      put_duty(1000, 1'b1);
      cyc(1030);
      i_pin_direction <= 1'b1;
      cyc(20);
      i_pin_direction <= 1'b0;
      i_rst <= 1'b1;
      cyc(2);
      i_rst <= 1'b0;
      cyc(1040);
      endt("resolution");
      test_done;
   end

   initial begin
      #(1_000_000);
      errors++;
      $display("watchdog expired");
      test_done;
   end
endmodule
